// ==== hw/usbir_pkg.sv ====
// Purpose: shared constants for the usb initialisation register bank
// Assumes: 100 MHz core clock, byte addresses as seen on the parallel host bus
// Notes:   timing figures are kept in milliseconds and converted to cycles here
package usbir_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_REG_OFS = 8'h00;
	localparam logic [7:0] MODE_REG_OFS = 8'h0C;
	localparam logic [7:0] MODE_HI_OFS = 8'h0D; // upper byte on an 8-bit bus

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int ADDR_EN_BIT = 7;
	localparam int STRAP_HIGH_BIT = 15;
	localparam int STRAP_MID_BIT = 14;
	localparam int STRAP_LOW_BIT = 13;
	localparam int DMA_CLK_BIT = 9;
	localparam int VBUS_BIT = 8;
	localparam int KEEP_CLK_BIT = 7;
	localparam int RESUME_BIT = 6;
	localparam int SUSPEND_BIT = 5;
	localparam int SRESET_BIT = 4;
	localparam int IRQ_GATE_BIT = 3;
	localparam int WAKE_RD_BIT = 2;
	localparam int PIN_STYLE_BIT = 1;
	localparam int PULLUP_BIT = 0;

	// ************************************************************
	// reset values and masks
	// ************************************************************
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] MODE_WR_MASK = 16'h02FF; // storable mode bits
	localparam logic [15:0] MODE_BUS_RST_CLR = 16'h0274; // bits cleared by usb bus reset

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int SUSP_STOP_MS = 2;
	localparam int RESUME_DELAY_MS = 5;
	localparam int RESUME_LEN_MS = 10;
	localparam int SUSP_STOP_CYC = SUSP_STOP_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int RESUME_DELAY_CYC = RESUME_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int RESUME_LEN_CYC = RESUME_LEN_MS * NS_PER_MS / CLK_PERIOD_NS;

endpackage

// ==== hw/usbir_timer.sv ====
// Purpose: one-shot delay followed by a hold window
// Assumes: i_start is a single-cycle pulse
// Notes:   a new start while running restarts the sequence
module usbir_timer #(
	parameter int DELAY = 16,
	parameter int HOLD = 16
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// control
	input wire logic i_start,
	input wire logic i_abort,
	// results
	output logic o_fire,
	output logic o_hold
);

	localparam int CW = $clog2(DELAY + HOLD + 2);

	if (DELAY < 1 || HOLD < 1) begin : g_chk
		$error("usbir_timer: DELAY and HOLD must be at least 1");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_HOLD = 2'b10
	} usbir_tmr_t;

	usbir_tmr_t st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic fire_d;

	// next state: count the delay, pulse, then count the hold
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		fire_d = 1'b0;
		unique case (st_q)
			ST_IDLE: begin
			end
			ST_WAIT: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CW'(DELAY - 1)) begin
					st_d = ST_HOLD;
					cnt_d = '0;
					fire_d = 1'b1;
				end
			end
			ST_HOLD: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CW'(HOLD - 1)) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		if (i_start) begin
			st_d = ST_WAIT;
			cnt_d = '0;
		end
		if (i_abort) begin
			st_d = ST_IDLE;
			cnt_d = '0;
			fire_d = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			o_fire <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			o_fire <= fire_d;
		end
	end

	assign o_hold = (st_q == ST_HOLD);

endmodule

// ==== hw/usbir_regs.sv ====
// Purpose: address and mode registers of a usb peripheral controller
// Assumes: host strobes are one-cycle pulses synchronous to i_mclk
// Notes:   the three command bits act on the one-to-zero write
//
// How it works
// RULE1: 8-bit bus, low byte at lower address
// RULE2: 16-bit host ignores upper byte of bytes
// RULE3: host selects endpoint before endpoint registers
// RULE4: host writes zero to reserved bits
// RULE5: address register: address field plus enable
// RULE6: address cleared by all three resets
// RULE7: enable cleared by power/soft reset only
// RULE8: no usb responses while enable clear
// RULE9: firmware writes address then zero-length packet
// RULE10: new address active after status ack
// RULE11: mode register echoes three strap pins
// RULE12: bit 9 gates dma clock, resets zero
// RULE13: bit 8 shows live vbus level
// RULE14: bit 7 keeps clocks alive in suspend
// RULE15: clock stops 2 ms after suspend command
// RULE16: resume drives 10 ms, 5 ms later
// RULE17: bit 5 one-then-zero enters suspend
// RULE18: bit 4 one-then-zero soft resets
// RULE19: bit 3 gates all interrupts globally
// RULE20: bit 2 lets register read wake
// RULE21: bit 0 connects data-line pull-up
// RULE22: commands launch on one-to-zero write
module usbir_regs #(
	parameter int SUSP_STOP_CYC = usbir_pkg::SUSP_STOP_CYC,
	parameter int RESUME_DELAY_CYC = usbir_pkg::RESUME_DELAY_CYC,
	parameter int RESUME_LEN_CYC = usbir_pkg::RESUME_LEN_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// parallel host bus
	input wire logic i_bus_16,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata,
	// usb side events and pins
	input wire logic i_usb_bus_reset,
	input wire logic i_status_ack,
	input wire logic i_vbus,
	input wire logic i_strap_pin_high,
	input wire logic i_strap_pin_mid,
	input wire logic i_strap_pin_low,
	// controls to the rest of the chip
	output logic o_respond_enable,
	output logic [6:0] o_assigned_usb_address,
	output logic o_dma_clock_gate,
	output logic o_keep_clocks_in_suspend,
	output logic o_global_irq_gate,
	output logic o_suspend_pin_style,
	output logic o_pullup_connect,
	output logic o_suspended,
	output logic o_clock_stop,
	output logic o_resume_signal,
	output logic o_soft_reset
);

	if (SUSP_STOP_CYC < 1 || RESUME_DELAY_CYC < 1 || RESUME_LEN_CYC < 1) begin : g_chk
		$error("usbir_regs: timing counts must be at least 1");
	end

	// ************************************************************
	// register state
	// ************************************************************
	logic [7:0] addr_q, addr_d;
	logic [15:0] mode_q, mode_d;
	logic [6:0] act_q, act_d;
	logic pend_q, pend_d;
	logic susp_q, susp_d;
	logic stop_q, stop_d;
	logic srst_q, srst_d;
	logic [15:0] rdata_q, rdata_d;
	logic susp_cmd, res_cmd, srst_cmd;
	logic stop_fire, res_fire, res_hold;

	// read value of a byte address; reserved bits read zero
	function automatic logic [15:0] read_word(input logic [7:0] a, input logic wide, input logic [7:0] adr,
		input logic [15:0] mode);
		logic [15:0] r;
		r = 16'h0000;
		if (a == usbir_pkg::ADDR_REG_OFS) begin
			r = {8'h00, adr};
		end else if (a == usbir_pkg::MODE_REG_OFS) begin
			r = wide ? mode : {8'h00, mode[7:0]};
		end else if (a == usbir_pkg::MODE_HI_OFS && !wide) begin
			r = {8'h00, mode[15:8]};
		end
		return r;
	endfunction

	// live mode view with straps and vbus
	logic [15:0] mode_view;
	always_comb begin
		mode_view = mode_q & usbir_pkg::MODE_WR_MASK;
		// RULE11: strap echo
		mode_view[usbir_pkg::STRAP_HIGH_BIT] = i_strap_pin_high;
		mode_view[usbir_pkg::STRAP_MID_BIT] = i_strap_pin_mid;
		mode_view[usbir_pkg::STRAP_LOW_BIT] = i_strap_pin_low;
		// RULE13: live vbus level
		mode_view[usbir_pkg::VBUS_BIT] = i_vbus;
	end

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		addr_d = addr_q;
		mode_d = mode_q;
		act_d = act_q;
		pend_d = pend_q;
		susp_d = susp_q;
		stop_d = stop_q;
		srst_d = 1'b0;
		rdata_d = rdata_q;
		// RULE5: address register write
		if (i_wr && i_addr == usbir_pkg::ADDR_REG_OFS) begin
			addr_d = i_wdata[7:0];
			pend_d = 1'b1;
		end
		// RULE1: byte lanes follow the bus width
		if (i_wr && i_addr == usbir_pkg::MODE_REG_OFS) begin
			if (i_bus_16) begin
				mode_d = i_wdata & usbir_pkg::MODE_WR_MASK;
			end else begin
				mode_d[7:0] = i_wdata[7:0];
			end
		end
		if (i_wr && !i_bus_16 && i_addr == usbir_pkg::MODE_HI_OFS) begin
			mode_d[15:8] = i_wdata[7:0] & usbir_pkg::MODE_WR_MASK[15:8];
		end
		// RULE22: act on one-to-zero of a command bit
		susp_cmd = mode_q[usbir_pkg::SUSPEND_BIT] & ~mode_d[usbir_pkg::SUSPEND_BIT];
		res_cmd = mode_q[usbir_pkg::RESUME_BIT] & ~mode_d[usbir_pkg::RESUME_BIT];
		srst_cmd = mode_q[usbir_pkg::SRESET_BIT] & ~mode_d[usbir_pkg::SRESET_BIT];
		// RULE10: take the new address on status ack
		if (i_status_ack && pend_q) begin
			act_d = addr_q[6:0];
			pend_d = 1'b0;
		end
		// RULE14: clock stops only when not kept alive
		if (stop_fire && susp_q && !mode_q[usbir_pkg::KEEP_CLK_BIT]) begin
			stop_d = 1'b1;
		end
		// RULE20: with bit 2 set, any register read strobe wakes the chip
		if (i_rd && susp_q && mode_q[usbir_pkg::WAKE_RD_BIT]) begin
			susp_d = 1'b0;
			stop_d = 1'b0;
		end
		// remote wake leaves suspend when signalling starts
		if (res_fire) begin
			susp_d = 1'b0;
			stop_d = 1'b0;
		end
		// RULE17: enter suspend
		// placed after the resume clear so a same-cycle command still wins
		if (susp_cmd) begin
			susp_d = 1'b1;
		end
		if (i_rd) begin
			rdata_d = read_word(i_addr, i_bus_16, addr_q, mode_view);
		end
		// RULE6: bus reset clears address; RULE7: enable kept
		if (i_usb_bus_reset) begin
			addr_d[6:0] = 7'h00;
			act_d = 7'h00;
			pend_d = 1'b0;
			mode_d = mode_d & ~usbir_pkg::MODE_BUS_RST_CLR;
		end
		// RULE18: soft reset one cycle after the command
		srst_d = srst_cmd;
		if (srst_q) begin
			addr_d = usbir_pkg::ADDR_RESET;
			mode_d = usbir_pkg::MODE_RESET;
			act_d = 7'h00;
			pend_d = 1'b0;
			susp_d = 1'b0;
			stop_d = 1'b0;
			srst_d = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			addr_q <= usbir_pkg::ADDR_RESET;
			mode_q <= usbir_pkg::MODE_RESET;
			act_q <= 7'h00;
			pend_q <= 1'b0;
			susp_q <= 1'b0;
			stop_q <= 1'b0;
			srst_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			addr_q <= addr_d;
			mode_q <= mode_d;
			act_q <= act_d;
			pend_q <= pend_d;
			susp_q <= susp_d;
			stop_q <= stop_d;
			srst_q <= srst_d;
			rdata_q <= rdata_d;
		end
	end

	// ************************************************************
	// timers
	// ************************************************************
	// RULE15: clock-stop delay after suspend command
	usbir_timer #(.DELAY(SUSP_STOP_CYC), .HOLD(1)) u_stop (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_start(susp_cmd),
		.i_abort(srst_q),
		.o_fire(stop_fire),
		.o_hold()
	);

	// RULE16: resume gap then resume window
	usbir_timer #(.DELAY(RESUME_DELAY_CYC), .HOLD(RESUME_LEN_CYC)) u_res (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_start(res_cmd),
		.i_abort(srst_q),
		.o_fire(res_fire),
		.o_hold(res_hold)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_rdata = rdata_q;
	// RULE8: no usb response unless enabled
	assign o_respond_enable = addr_q[usbir_pkg::ADDR_EN_BIT];
	assign o_assigned_usb_address = act_q;
	// RULE12: dma clock gate
	assign o_dma_clock_gate = mode_q[usbir_pkg::DMA_CLK_BIT];
	assign o_keep_clocks_in_suspend = mode_q[usbir_pkg::KEEP_CLK_BIT];
	// RULE19: global interrupt gate
	assign o_global_irq_gate = mode_q[usbir_pkg::IRQ_GATE_BIT];
	assign o_suspend_pin_style = mode_q[usbir_pkg::PIN_STYLE_BIT];
	// RULE21: pull-up connect
	assign o_pullup_connect = mode_q[usbir_pkg::PULLUP_BIT];
	assign o_suspended = susp_q;
	assign o_clock_stop = stop_q;
	assign o_resume_signal = res_hold;
	assign o_soft_reset = srst_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	property p_addr_busrst;
		i_usb_bus_reset |=> (addr_q[6:0] == 7'h00) && (o_assigned_usb_address == 7'h00);
	endproperty
	a_addr_busrst: assert property (p_addr_busrst) else $error("address not cleared by bus reset"); // RULE6

	property p_en_kept;
		i_usb_bus_reset && !srst_q && !(i_wr && i_addr == usbir_pkg::ADDR_REG_OFS)
			|=> o_respond_enable == $past(o_respond_enable);
	endproperty
	a_en_kept: assert property (p_en_kept) else $error("enable changed on bus reset"); // RULE7

	property p_srst;
		srst_cmd && !srst_q |=> o_soft_reset ##1 (!o_respond_enable && !o_dma_clock_gate && !o_suspended);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset did not clear state"); // RULE18

	property p_addr_hold;
		pend_q && !i_status_ack && !i_usb_bus_reset && !srst_q |=> $stable(o_assigned_usb_address);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address changed before status ack"); // RULE10

	property p_addr_take;
		pend_q && i_status_ack && !i_usb_bus_reset && !srst_q |=> o_assigned_usb_address == $past(addr_q[6:0]);
	endproperty
	a_addr_take: assert property (p_addr_take) else $error("address not taken on status ack"); // RULE10

	property p_vbus;
		i_rd && i_bus_16 && i_addr == usbir_pkg::MODE_REG_OFS |=> o_rdata[usbir_pkg::VBUS_BIT] == $past(i_vbus);
	endproperty
	a_vbus: assert property (p_vbus) else $error("vbus bit wrong"); // RULE13

	property p_susp;
		susp_cmd && !srst_q && !i_rd && !res_fire |=> o_suspended;
	endproperty
	a_susp: assert property (p_susp) else $error("suspend not entered"); // RULE17

	property p_stop_keep;
		$rose(o_clock_stop) |-> $past(!o_keep_clocks_in_suspend) && $past(stop_fire);
	endproperty
	a_stop_keep: assert property (p_stop_keep) else $error("clock stopped while kept alive"); // RULE14

	property p_wake;
		i_rd && o_suspended && mode_q[usbir_pkg::WAKE_RD_BIT] |=> !o_suspended && !o_clock_stop;
	endproperty
	a_wake: assert property (p_wake) else $error("read did not wake"); // RULE20

	property p_res_gap;
		res_cmd && !srst_q |=> !o_resume_signal [*2];
	endproperty
	a_res_gap: assert property (p_res_gap) else $error("resume began without gap"); // RULE16

	c_susp: cover property (susp_cmd ##1 o_suspended);
	c_stop: cover property ($rose(o_clock_stop));
	c_res: cover property ($rose(o_resume_signal));
	c_take: cover property (pend_q && i_status_ack);

endmodule

// ==== dv/usbir_host_model.sv ====
// Purpose: host microcontroller model on the parallel register bus
// Assumes: strobes change just after a rising edge of i_mclk
// Notes:   released address and data lines show the inverse of their last value
module usbir_host_model (
	// clock and width strap
	input wire logic i_mclk,
	input wire logic i_bus_16,
	// bus to the device
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [15:0] o_wdata,
	input wire logic [15:0] i_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus at time zero
	initial begin
		o_addr = 8'hff;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 16'hffff;
	end

	// one strobe cycle; lines flip afterwards so stale data never looks valid
	task automatic cyc(input logic [7:0] a, input logic [15:0] d, input logic w);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= w;
		o_rd <= !w;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	task automatic write8(input logic [7:0] a, input logic [7:0] d);
		cyc(a, {8'h00, d}, 1'b1);
	endtask

	task automatic write16(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] m;
		m = d & usbir_pkg::MODE_WR_MASK;
		if (i_bus_16) begin
			cyc(a, m, 1'b1);
		end else begin
			cyc(a, {8'h00, m[7:0]}, 1'b1);
			cyc(a + 8'h01, {8'h00, m[15:8]}, 1'b1);
		end
	endtask

	task automatic read8(input logic [7:0] a, output logic [7:0] q);
		cyc(a, 16'h0000, 1'b0);
		@(posedge i_mclk);
		#1 q = i_rdata[7:0];
	endtask

	task automatic read16(input logic [7:0] a, output logic [15:0] q);
		logic [7:0] lo;
		logic [7:0] hi;
		if (i_bus_16) begin
			cyc(a, 16'h0000, 1'b0);
			@(posedge i_mclk);
			#1 q = i_rdata;
		end else begin
			read8(a, lo);
			read8(a + 8'h01, hi);
			q = {hi, lo};
		end
	endtask
endmodule

// ==== dv/usbir_regs_test.sv ====
// Purpose: self-checking bench for the usb initialisation registers
// Assumes: short timer parameters so suspend and resume finish quickly
// Notes:   random straps, vbus and mode values come from an lfsr seeded at 83
module usbir_regs_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// stimulus and design
	// ************************************************************
	localparam int SUSP = 20;
	localparam int RDLY = 10;
	localparam int RLEN = 20;
	localparam logic [7:0] MO = usbir_pkg::MODE_REG_OFS;
	localparam logic [7:0] AO = usbir_pkg::ADDR_REG_OFS;
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_bus_16 = 1'b1;
	logic i_usb_bus_reset = 1'b0, i_status_ack = 1'b0, i_vbus = 1'b0;
	logic i_strap_pin_high = 1'b0, i_strap_pin_mid = 1'b0, i_strap_pin_low = 1'b0;
	logic [7:0] i_addr;
	logic i_wr, i_rd;
	logic [15:0] i_wdata, o_rdata, q, v;
	logic o_respond_enable, o_dma_clock_gate, o_keep_clocks_in_suspend, o_global_irq_gate;
	logic o_suspend_pin_style, o_pullup_connect, o_suspended, o_clock_stop, o_resume_signal, o_soft_reset;
	logic [6:0] o_assigned_usb_address, a;
	logic [7:0] lfsr = 8'h53, b;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;

	// half-period clock toggle
	always #5 i_mclk = ~i_mclk;

	usbir_host_model u_host (.i_mclk(i_mclk), .i_bus_16(i_bus_16), .o_addr(i_addr), .o_wr(i_wr),
		.o_rd(i_rd), .o_wdata(i_wdata), .i_rdata(o_rdata));

	usbir_regs #(.SUSP_STOP_CYC(SUSP), .RESUME_DELAY_CYC(RDLY), .RESUME_LEN_CYC(RLEN)) u_dut (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus_16(i_bus_16), .i_addr(i_addr), .i_wr(i_wr),
		.i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_usb_bus_reset(i_usb_bus_reset),
		.i_status_ack(i_status_ack), .i_vbus(i_vbus), .i_strap_pin_high(i_strap_pin_high),
		.i_strap_pin_mid(i_strap_pin_mid), .i_strap_pin_low(i_strap_pin_low),
		.o_respond_enable(o_respond_enable), .o_assigned_usb_address(o_assigned_usb_address),
		.o_dma_clock_gate(o_dma_clock_gate), .o_keep_clocks_in_suspend(o_keep_clocks_in_suspend),
		.o_global_irq_gate(o_global_irq_gate), .o_suspend_pin_style(o_suspend_pin_style),
		.o_pullup_connect(o_pullup_connect), .o_suspended(o_suspended), .o_clock_stop(o_clock_stop),
		.o_resume_signal(o_resume_signal), .o_soft_reset(o_soft_reset));

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// mode word as read back: live straps and vbus around the stored bits
	function automatic logic [15:0] mode_exp(input logic [15:0] st);
		return {i_strap_pin_high, i_strap_pin_mid, i_strap_pin_low, 3'b000, st[9], i_vbus, st[7:0]};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge i_mclk);
		#1;
	endtask

	// count edges until a flag rises, bounded so a stuck flag cannot hang
	// sel low watches the clock stop, sel high the resume signal
	task automatic wait_hi(input logic sel);
		n = 0;
		while ((sel ? o_resume_signal : o_clock_stop) !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hang guard: the whole sequence needs far fewer cycles
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (16) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		{i_strap_pin_high, i_strap_pin_mid, i_strap_pin_low, i_vbus} <= 4'hb;
		u_host.read16(MO, q);
		chk(q, mode_exp(usbir_pkg::MODE_RESET), "mode reset");
		u_host.read8(AO, b);
		chk({8'h00, b}, 16'h0000, "addr reset");
		chk({15'h0000, o_respond_enable}, 16'h0000, "enable reset");
		$display("test reset done");
		// random mode words on both widths, command bits left clear
		for (int k = 0; k < 8; k++) begin
			lfsr = lfsr_next(lfsr);
			v = {6'h00, lfsr[0], 1'b0, lfsr[7], 3'b000, lfsr[3:0]};
			@(posedge i_mclk);
			i_bus_16 <= k[0];
			{i_strap_pin_high, i_strap_pin_mid, i_strap_pin_low, i_vbus} <= lfsr[7:4];
			// let the new width settle so the host picks the matching byte lanes
			@(posedge i_mclk);
			u_host.write16(MO, v);
			u_host.read16(MO, q);
			chk(q, mode_exp(v), "mode readback");
			chk({11'h000, o_dma_clock_gate, o_keep_clocks_in_suspend, o_global_irq_gate, o_suspend_pin_style,
				o_pullup_connect}, {11'h000, v[9], v[7], v[3], v[1], v[0]}, "mode outputs");
		end
		$display("test mode done");
		@(posedge i_mclk);
		i_bus_16 <= 1'b1;
		lfsr = lfsr_next(lfsr);
		a = lfsr[6:0] | 7'h01;
		u_host.write8(AO, {1'b1, a});
		tick();
		chk({15'h0000, o_respond_enable}, 16'h0001, "enable set");
		chk({9'h000, o_assigned_usb_address}, 16'h0000, "address before ack");
		@(posedge i_mclk);
		i_status_ack <= 1'b1;
		@(posedge i_mclk);
		i_status_ack <= 1'b0;
		tick();
		chk({9'h000, o_assigned_usb_address}, {9'h000, a}, "address after ack");
		u_host.read8(AO, b);
		chk({8'h00, b}, {8'h00, 1'b1, a}, "address readback");
		$display("test address done");
		u_host.write16(MO, 16'h028f);
		@(posedge i_mclk);
		i_usb_bus_reset <= 1'b1;
		@(posedge i_mclk);
		i_usb_bus_reset <= 1'b0;
		u_host.read8(AO, b);
		chk({8'h00, b}, 16'h0080, "address after bus reset");
		chk({9'h000, o_assigned_usb_address}, 16'h0000, "active address bus reset");
		u_host.read16(MO, q);
		chk(q, mode_exp(16'h008b), "mode after bus reset");
		$display("test bus reset done");
		u_host.write16(MO, 16'h00a4);
		tick();
		chk({15'h0000, o_suspended}, 16'h0000, "set alone");
		u_host.write16(MO, 16'h0084);
		tick();
		chk({15'h0000, o_suspended}, 16'h0001, "suspended");
		repeat (SUSP + 10) tick();
		chk({15'h0000, o_clock_stop}, 16'h0000, "clocks kept");
		u_host.read16(MO, q);
		chk({15'h0000, o_suspended}, 16'h0000, "read wake");
		u_host.write16(MO, 16'h0024);
		u_host.write16(MO, 16'h0004);
		wait_hi(1'b0);
		chk({15'h0000, 1'(n >= SUSP - 1 && n <= SUSP + 4)}, 16'h0001, "clock stop delay");
		u_host.read16(MO, q);
		chk({14'h0000, o_suspended, o_clock_stop}, 16'h0000, "read restarts clock");
		$display("test suspend done");
		u_host.write16(MO, 16'h0040);
		u_host.write16(MO, 16'h0000);
		wait_hi(1'b1);
		chk({15'h0000, 1'(n >= RDLY - 1 && n <= RDLY + 3)}, 16'h0001, "resume delay");
		n = 0;
		while (o_resume_signal === 1'b1 && n < 200) begin
			tick();
			n++;
		end
		chk({15'h0000, 1'(n >= RLEN - 1 && n <= RLEN + 1)}, 16'h0001, "resume length");
		$display("test resume done");
		u_host.write8(AO, {1'b1, a});
		u_host.write16(MO, 16'h0293);
		u_host.write16(MO, 16'h0283);
		// the pulse stands only in the cycle after the zero write
		#1;
		chk({15'h0000, o_soft_reset}, 16'h0001, "soft reset pulse");
		tick();
		chk({o_soft_reset, o_respond_enable, o_dma_clock_gate, o_pullup_connect, 12'h000}, 16'h0000,
			"soft reset clears");
		u_host.read8(AO, b);
		chk({8'h00, b}, 16'h0000, "address after soft reset");
		u_host.read16(MO, q);
		chk(q, mode_exp(16'h0000), "mode after soft reset");
		$display("test soft reset done");
		final_report();
	end
endmodule
